// [verif/slave_link_model.sv]
// Slave controller model on the far side of the serial link
`timescale 1ns/1ps
module slave_link_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic linkReqValid,
  input wire logic linkReqKind,
  output logic linkReqReady,
  output logic [6:0] linkRdIdx,
  input wire logic [15:0] linkRdData,
  output logic rspValid,
  output logic rspOk,
  output logic [7:0] rspId,
  input wire logic [1:0] mode,
  input wire logic [7:0] idSel,
  input wire logic [3:0] delay,
  output int reqCount,
  output int errCount
);
  logic [3:0] cnt;
  logic pend;
  logic kindPrev;
  // Peek at the command word while the request stands
  assign linkRdIdx = 7'h06;
  // One-cycle ready, delayed reply; mode 1 stays silent, mode 2 refuses
  always @(posedge clk) begin
    if (rst) begin
      linkReqReady <= 1'b0;
      rspValid <= 1'b0;
      rspOk <= 1'b0;
      rspId <= 8'h00;
      reqCount <= 0;
      errCount <= 0;
      cnt <= 4'h0;
      pend <= 1'b0;
      kindPrev <= 1'b1;
    end else begin
      linkReqReady <= linkReqValid && !linkReqReady;
      rspValid <= 1'b0;
      // Reply lines toggle between replies so stale values never look valid
      rspOk <= ~rspOk;
      rspId <= ~rspId;
      if (linkReqValid && linkReqReady) begin
        reqCount <= reqCount + 1;
        pend <= (mode != 2'h1);
        cnt <= delay;
        kindPrev <= linkReqKind;
        if (linkReqKind ? (kindPrev !== 1'b0) : (linkRdData !== 16'h1C2F)) begin
          errCount <= errCount + 1;
        end
      end else if (pend && cnt == 4'h0) begin
        pend <= 1'b0;
        rspValid <= 1'b1;
        rspOk <= (mode != 2'h2);
        // Second reply carries a wrong identifier, which must be ignored
        rspId <= kindPrev ? ~idSel : idSel;
      end else if (pend) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule // slave_link_model

// [verif/test_datagram_establish_command.sv]
// Self-checking bench of the establish-datagram command interpreter
`timescale 1ns/1ps
`include "dg_consts.svh"
module test_datagram_establish_command;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, attached = 1'b1, cancelPerm = 1'b0;
  logic [11:0] wbAdr = 12'h000;
  logic [31:0] wbDo = 32'h0, wbDi;
  logic [4:0] evt = 5'h00;
  logic [7:0] cancelId = 8'h00, idSel = 8'h05, rspId;
  logic wbAck, linkReqValid, linkReqReady, linkReqKind, rspValid, rspOk, memWrValid, busy;
  logic [6:0] linkRdIdx;
  logic [15:0] linkRdData, memWrType, memWrAddr, memWrData;
  logic memWrReady = 1'b0;
  logic ce = 1'b1;
  logic [3:0] wbSel = 4'h3;
  logic [1:0] mode = 2'h0;
  logic [3:0] delay = 4'h0;
  int reqCount, errCount;
  int miscompares = 0, cmpCount = 0, memCnt = 0;
  logic [15:0] blk [1:23];
  logic [15:0] memT [0:3], memA [0:3], memD [0:3];
  int eW [11] = '{7, 8, 9, 9, 17, 17, 1, 20, 20, 18, 18};
  logic [15:0] eV [11] = '{16'h1C2E, 16'h0002, 16'h0000, 16'h0080, 16'h0000, 16'h0021,
    16'h0012, 16'h0000, 16'h0101, 16'h0046, 16'h00B8};
  logic [15:0] eC [11] = '{`DG_ST_BAD_CMD, `DG_ST_BAD_FAM, `DG_ST_BAD_TYPE, `DG_ST_BAD_TYPE,
    `DG_ST_BAD_NFMT, `DG_ST_BAD_NFMT, `DG_ST_BAD_LEN, `DG_ST_BAD_CNT, `DG_ST_BAD_CNT,
    `DG_ST_BIT_LARGE, `DG_ST_BIT_LARGE};

  always #12.5 clk = ~clk;
  // Memory side stalls every other cycle
  always @(posedge clk) memWrReady <= ~memWrReady;
  // Log of master memory writes, in order
  always @(posedge clk) begin
    if (memWrValid && memWrReady && memCnt < 4) begin
      memT[memCnt] <= memWrType;
      memA[memCnt] <= memWrAddr;
      memD[memCnt] <= memWrData;
      memCnt <= memCnt + 1;
    end
  end

  datagram_establish_command #(.TIMEOUT_CYCLES(50)) i_datagram_establish_command (
    .clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_dat_i(wbDo), .wb_sel_i(wbSel), .wb_dat_o(wbDi), .wb_ack_o(wbAck),
    .slaveAttached(attached), .attachEvt(evt[0]), .rtUpdEvt(evt[1]), .cancelEvt(evt[4]),
    .cancelId(cancelId), .cancelPerm(cancelPerm), .powerLoss(evt[2]), .progDelete(evt[3]),
    .linkReqValid(linkReqValid), .linkReqReady(linkReqReady), .linkReqKind(linkReqKind),
    .linkRdIdx(linkRdIdx), .linkRdData(linkRdData), .rspValid(rspValid), .rspOk(rspOk),
    .rspId(rspId), .memWrValid(memWrValid), .memWrReady(memWrReady), .memWrType(memWrType),
    .memWrAddr(memWrAddr), .memWrData(memWrData), .busy(busy));

  slave_link_model i_slave_link_model (
    .clk(clk), .rst(rst), .linkReqValid(linkReqValid), .linkReqKind(linkReqKind),
    .linkReqReady(linkReqReady), .linkRdIdx(linkRdIdx), .linkRdData(linkRdData),
    .rspValid(rspValid), .rspOk(rspOk), .rspId(rspId), .mode(mode), .idSel(idSel),
    .delay(delay), .reqCount(reqCount), .errCount(errCount));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    cmpCount++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Classic single cycle; the request stands until ack is sampled high
  task automatic wbXfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDo <= d;
    do @(posedge clk); while (wbAck !== 1'b1);
    q = wbDi;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask

  // Example request: permanent, larger family, two byte-mode formats
  task automatic setEx();
    blk = '{16'h0011, 16'h0000, 16'h0008, 16'h0010, 16'h0000, 16'h0000,
      16'h1C2F, 16'h0000, 16'h0081, 16'h0016, 16'h0008, 16'h00A1,
      16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0002,
      16'h0008, 16'h00C9, 16'h000A, 16'h0010, 16'h0001, 16'h0002};
    attached <= 1'b1;
    mode <= 2'h0;
  endtask

  task automatic runCmd(input string nm, input logic [15:0] code, input int links);
    logic [31:0] q;
    int i;
    int base;
    base = reqCount;
    memCnt = 0;
    for (i = 1; i <= 23; i++) wbXfer(1'b1, 12'(4 * (i - 1)), {16'h0000, blk[i]}, q);
    wbXfer(1'b1, `DG_A_CTRL, 32'h1, q);
    chk({nm, " busy"}, 32'h1, {31'h0, busy});
    // Poll is bounded by the watchdog
    do wbXfer(1'b0, `DG_A_CTRL, 32'h0, q); while (q[0] !== 1'b0);
    chk({nm, " idle"}, 32'h0, {31'h0, busy});
    wbXfer(1'b0, `DG_A_STATUS, 32'h0, q);
    chk({nm, " status reg"}, {16'h0000, code}, q);
    chk({nm, " link requests"}, links, reqCount - base);
    chk({nm, " status type"}, blk[3], memT[memCnt - 1]);
    chk({nm, " status addr"}, blk[4] + 16'h1, memA[memCnt - 1]);
    chk({nm, " status data"}, code, memD[memCnt - 1]);
    chk({nm, " write count"}, (code == `DG_ST_OK) ? 2 : 1, memCnt);
    $display("test %s done", nm);
  endtask

  task automatic chkId(input logic [7:0] id);
    logic [31:0] q;
    chk("id type", blk[11], memT[0]);
    chk("id addr", blk[12], memA[0]);
    chk("id data", {8'h00, id}, memD[0]);
    wbXfer(1'b0, `DG_A_ID, 32'h0, q);
    chk("id reg", {23'h0, 1'b1, id}, q);
  endtask

  task automatic query(input logic [7:0] id, input logic v);
    logic [31:0] q;
    wbXfer(1'b1, `DG_A_QUERY, {24'h0, id}, q);
    wbXfer(1'b0, `DG_A_QUERY, 32'h0, q);
    chk("query", {23'h0, v, id}, q);
  endtask

  // Establish, then one lifetime event, then look the identifier up again
  task automatic life(input logic [15:0] t, input logic [7:0] id, input int ev, input logic v);
    setEx();
    blk[9] = t;
    idSel <= id;
    cancelId <= id;
    cancelPerm <= t[7];
    runCmd("life", `DG_ST_OK, 2);
    chkId(id);
    query(id, 1'b1);
    evt[ev] <= 1'b1;
    @(posedge clk);
    evt <= 5'h00;
    @(posedge clk);
    query(id, v);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    conclude();
  end

  initial begin
    logic [31:0] q;
    int k;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wbXfer(1'b0, `DG_A_STATUS, 32'h0, q);
    chk("status after reset", 32'h0, q);
    wbXfer(1'b1, 12'h300, 32'h5A5A_5A5A, q);
    wbXfer(1'b0, 12'h300, 32'h0, q);
    chk("unmapped read", 32'h0, q);
    setEx();
    runCmd("good", `DG_ST_OK, 2);
    chkId(8'h05);
    delay <= 4'h9;
    idSel <= 8'hC3;
    setEx();
    runCmd("slow reply", `DG_ST_OK, 2);
    chkId(8'hC3);
    // Frozen clock enable holds every state, so the bus gets no answer
    ce <= 1'b0;
    fork
      wbXfer(1'b0, `DG_A_ID, 32'h0, q);
      begin
        repeat (4) @(posedge clk);
        chk("ack while frozen", 32'h0, {31'h0, wbAck});
        ce <= 1'b1;
      end
    join
    chk("id after freeze", {23'h0, 1'b1, 8'hC3}, q);
    $display("test freeze done");
    delay <= 4'h0;
    for (k = 0; k < 11; k++) begin
      setEx();
      blk[eW[k]] = eV[k];
      runCmd("bad field", eC[k], 0);
    end
    setEx();
    attached <= 1'b0;
    runCmd("detached", `DG_ST_NOT_ATT, 0);
    setEx();
    blk[20] = 16'h0100;
    runCmd("count max", `DG_ST_OK, 2);
    setEx();
    blk[8] = 16'h0001;
    blk[18] = 16'h0046;
    blk[19] = 16'h0005;
    blk[20] = 16'h0004;
    runCmd("bit fit", `DG_ST_OK, 2);
    blk[20] = 16'h0005;
    runCmd("bit span", `DG_ST_BIT_SPAN, 0);
    setEx();
    mode <= 2'h1;
    runCmd("silent", `DG_ST_TIMEOUT, 1);
    setEx();
    mode <= 2'h2;
    runCmd("refused", `DG_ST_REJECT, 1);
    life(`DG_TYPE_NORMAL, 8'h03, 0, 1'b0);
    life(`DG_TYPE_NORMAL, 8'h09, 1, 1'b0);
    life(`DG_TYPE_NORMAL, 8'h0A, 2, 1'b1);
    life(`DG_TYPE_PERM, 8'h04, 0, 1'b1);
    life(`DG_TYPE_PERM, 8'h05, 2, 1'b0);
    life(`DG_TYPE_PERM, 8'h06, 3, 1'b0);
    life(`DG_TYPE_PERM, 8'h07, 4, 1'b0);
    // Low byte lane off: the lookup identifier must not move
    wbSel <= 4'h2;
    wbXfer(1'b1, `DG_A_QUERY, 32'h77, q);
    wbSel <= 4'h3;
    wbXfer(1'b0, `DG_A_QUERY, 32'h0, q);
    chk("query lane", {23'h0, 1'b0, 8'h07}, q);
    $display("test byte lane done");
    chk("link order", 0, errCount);
    conclude();
  end
endmodule // test_datagram_establish_command

// [verilog/datagram_establish_command.sv]
// Establish-datagram command interpreter with Wishbone register access
//
// Behaviour
// - Establish request, identifier reply, write-datagram request, second reply.
// - Normal identifier dies at the next attach or real-time update.
// - Permanent identifier lives until cancel, power loss or program delete.
// - Returned one-byte identifier is written to the requested master location.
// - Larger family rejects bit-mode point formats.
// - Completion status goes to the type and address-plus-one in words 2, 3.
// - Identifier may be looked up until cancelled or invalidated.
`timescale 1ns/1ps
`include "dg_consts.svh"
module datagram_establish_command
  import dg_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = `DG_TIMEOUT_US * (`DG_CLK_KHZ / 1000)
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic slaveAttached,
  input wire logic attachEvt,
  input wire logic rtUpdEvt,
  input wire logic cancelEvt,
  input wire logic [7:0] cancelId,
  input wire logic cancelPerm,
  input wire logic powerLoss,
  input wire logic progDelete,
  output logic linkReqValid,
  input wire logic linkReqReady,
  output logic linkReqKind,
  input wire logic [6:0] linkRdIdx,
  output logic [15:0] linkRdData,
  input wire logic rspValid,
  input wire logic rspOk,
  input wire logic [7:0] rspId,
  output logic memWrValid,
  input wire logic memWrReady,
  output logic [15:0] memWrType,
  output logic [15:0] memWrAddr,
  output logic [15:0] memWrData,
  output logic busy
);
  top_state_type s_r;
  top_state_type s_nxt;
  logic queryValid;
  logic fmtIsBit;
  logic [15:0] fmtErr;
  logic [6:0] fmtBase;
  logic [15:0] nFmt;
  logic busAcc;
  logic [6:0] blkIdx;
  logic goReq;
  logic [15:0] hdrErr;

  // Current point format under check
  assign fmtBase = 7'(`DG_W_FMT0 + int'(`DG_FMT_WORDS) * int'(s_r.fmtIdx));
  assign nFmt = s_r.blk[`DG_W_NFMT];

  dg_fmt_check u_fmt (
    .family(s_r.blk[`DG_W_FAMILY]),
    .memType(s_r.blk[fmtBase]),
    .startAddr(s_r.blk[7'(fmtBase + 7'd1)]),
    .count(s_r.blk[7'(fmtBase + 7'd2)]),
    .isBit(fmtIsBit),
    .errCode(fmtErr)
  );

  dg_table u_table (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .setValid(s_r.setV),
    .setId(s_r.id),
    .setPerm(s_r.blk[`DG_W_DTYPE] == `DG_TYPE_PERM),
    .attachEvt(attachEvt),
    .rtUpdEvt(rtUpdEvt),
    .cancelEvt(cancelEvt),
    .cancelId(cancelId),
    .cancelPerm(cancelPerm),
    .powerLoss(powerLoss),
    .progDelete(progDelete),
    .queryId(s_r.queryId),
    .queryValid(queryValid)
  );

  // Bus decode
  assign busAcc = wb_cyc_i && wb_stb_i && !s_r.ack;
  assign blkIdx = wb_adr_i[8:2];
  assign goReq = busAcc && wb_we_i && wb_sel_i[0] && wb_dat_i[0] && wb_adr_i == `DG_A_CTRL;

  // Header checks done at start, before any format is examined
  always_comb begin
    hdrErr = 16'h0000;
    if (s_r.blk[`DG_W_CMD] != `DG_CMD_ESTABLISH) begin
      hdrErr = `DG_ST_BAD_CMD;
    end else if (!slaveAttached) begin
      hdrErr = `DG_ST_NOT_ATT;
    end else if (s_r.blk[`DG_W_FAMILY] != `DG_FAM_LARGE &&
                 s_r.blk[`DG_W_FAMILY] != `DG_FAM_SMALL) begin
      hdrErr = `DG_ST_BAD_FAM;
    end else if (s_r.blk[`DG_W_DTYPE] != `DG_TYPE_NORMAL &&
                 s_r.blk[`DG_W_DTYPE] != `DG_TYPE_PERM) begin
      hdrErr = `DG_ST_BAD_TYPE;
    end else if (nFmt == 16'h0000 || nFmt > `DG_MAX_FMT) begin
      hdrErr = `DG_ST_BAD_NFMT;
    end else if (s_r.blk[`DG_W_LEN] != 16'(nFmt * `DG_FMT_WORDS + `DG_LEN_BASE)) begin
      hdrErr = `DG_ST_BAD_LEN;
    end
  end

  // Bus slave and command sequencer
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack = busAcc;
    s_nxt.setV = 1'b0;
    if (busAcc) begin
      s_nxt.rdat = 32'h0000_0000;
      if (wb_adr_i < `DG_A_BLK_END && wb_adr_i[1:0] == 2'b00) begin
        s_nxt.rdat = {16'h0000, s_r.blk[blkIdx]};
        // Block is frozen while a command runs so checked data cannot change
        if (wb_we_i && s_r.st == S_IDLE) begin
          if (wb_sel_i[0]) begin
            s_nxt.blk[blkIdx][7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            s_nxt.blk[blkIdx][15:8] = wb_dat_i[15:8];
          end
        end
      end else if (wb_adr_i == `DG_A_CTRL) begin
        s_nxt.rdat = {31'h0000_0000, s_r.st != S_IDLE};
      end else if (wb_adr_i == `DG_A_STATUS) begin
        s_nxt.rdat = {16'h0000, s_r.code};
      end else if (wb_adr_i == `DG_A_ID) begin
        s_nxt.rdat = {23'h00_0000, s_r.idValid, s_r.id};
      end else if (wb_adr_i == `DG_A_QUERY) begin
        s_nxt.rdat = {23'h00_0000, queryValid, s_r.queryId};
        if (wb_we_i && wb_sel_i[0]) begin
          s_nxt.queryId = wb_dat_i[7:0];
        end
      end
    end
    unique case (s_r.st)
      S_IDLE: begin
        if (goReq) begin
          s_nxt.idValid = 1'b0;
          s_nxt.estDone = 1'b0;
          s_nxt.fmtIdx = 6'h00;
          s_nxt.chkOk = 1'b0;
          if (hdrErr != 16'h0000) begin
            s_nxt.code = hdrErr;
            s_nxt.st = S_WRSTAT;
          end else begin
            s_nxt.st = S_CHECK;
          end
        end
      end
      S_CHECK: begin
        if (fmtErr != 16'h0000) begin
          s_nxt.code = fmtErr;
          s_nxt.st = S_WRSTAT;
        end else if (16'(s_r.fmtIdx) + 16'h0001 == nFmt) begin
          s_nxt.chkOk = 1'b1;
          s_nxt.lreqV = 1'b1;
          s_nxt.lreqK = `DG_LK_EST;
          s_nxt.st = S_SEND1;
        end else begin
          s_nxt.fmtIdx = s_r.fmtIdx + 6'h01;
        end
      end
      S_SEND1, S_SEND2: begin
        if (linkReqReady) begin
          s_nxt.lreqV = 1'b0;
          s_nxt.tmr = 32'h0000_0000;
          s_nxt.st = (s_r.st == S_SEND1) ? S_WAIT1 : S_WAIT2;
        end
      end
      S_WAIT1, S_WAIT2: begin
        s_nxt.tmr = s_r.tmr + 32'h0000_0001;
        if (rspValid && !rspOk) begin
          s_nxt.code = `DG_ST_REJECT;
          s_nxt.st = S_WRSTAT;
        end else if (rspValid && s_r.st == S_WAIT1) begin
          s_nxt.id = rspId;
          s_nxt.estDone = 1'b1;
          s_nxt.lreqV = 1'b1;
          s_nxt.lreqK = `DG_LK_WRITE;
          s_nxt.st = S_SEND2;
        end else if (rspValid) begin
          // Slave confirmed: store identifier in master memory
          s_nxt.memV = 1'b1;
          s_nxt.memT = s_r.blk[`DG_W_IDTYPE];
          s_nxt.memA = s_r.blk[`DG_W_IDADDR];
          s_nxt.memD = {8'h00, s_r.id};
          s_nxt.st = S_WRID;
        end else if (s_r.tmr >= 32'(TIMEOUT_CYCLES - 1)) begin
          s_nxt.code = `DG_ST_TIMEOUT;
          s_nxt.st = S_WRSTAT;
        end
      end
      S_WRID: begin
        if (memWrReady) begin
          s_nxt.memV = 1'b0;
          s_nxt.idValid = 1'b1;
          s_nxt.setV = 1'b1;
          s_nxt.code = `DG_ST_OK;
          s_nxt.st = S_WRSTAT;
        end
      end
      S_WRSTAT: begin
        // Status address is stored minus one
        s_nxt.memV = 1'b1;
        s_nxt.memT = s_r.blk[`DG_W_STYPE];
        s_nxt.memA = s_r.blk[`DG_W_SADDR] + 16'h0001;
        s_nxt.memD = s_r.code;
        if (s_r.memV && memWrReady) begin
          s_nxt.memV = 1'b0;
          s_nxt.st = S_IDLE;
        end
      end
    endcase
  end

  // All state frozen while ce is low
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
      s_r.st <= S_IDLE;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdat;
  assign linkReqValid = s_r.lreqV;
  assign linkReqKind = s_r.lreqK;
  assign linkRdData = (int'(linkRdIdx) < `DG_BLK_WORDS) ? s_r.blk[linkRdIdx] : 16'h0000;
  assign memWrValid = s_r.memV;
  assign memWrType = s_r.memT;
  assign memWrAddr = s_r.memA;
  assign memWrData = s_r.memD;
  assign busy = s_r.st != S_IDLE;

  AST_ORDER: assert property (@(posedge clk) disable iff (rst)
    linkReqValid && linkReqKind == `DG_LK_WRITE |-> s_r.estDone)
    else $error("write request before identifier reply");
  AST_NO_LINK_ON_ERR: assert property (@(posedge clk) disable iff (rst)
    linkReqValid |-> s_r.chkOk && s_r.code == $past(s_r.code, 1))
    else $error("link used before checks passed");
  AST_ID_STORE: assert property (@(posedge clk) disable iff (rst)
    memWrValid && s_r.st == S_WRID |->
      memWrData == {8'h00, s_r.id} && memWrAddr == s_r.blk[`DG_W_IDADDR] &&
      memWrType == s_r.blk[`DG_W_IDTYPE])
    else $error("identifier written to wrong place");
  AST_STATUS_ADDR: assert property (@(posedge clk) disable iff (rst)
    memWrValid && s_r.st == S_WRSTAT |->
      memWrAddr == s_r.blk[`DG_W_SADDR] + 16'h0001 && memWrData == s_r.code)
    else $error("status written to wrong address");
  AST_TIMEOUT: assert property (@(posedge clk) disable iff (rst)
    ce && (s_r.st == S_WAIT1 || s_r.st == S_WAIT2) && !rspValid &&
      s_r.tmr == 32'(TIMEOUT_CYCLES - 1) |=> s_r.st == S_WRSTAT && s_r.code == `DG_ST_TIMEOUT)
    else $error("missing timeout");
  AST_BIT_LARGE: assert property (@(posedge clk) disable iff (rst)
    ce && s_r.st == S_CHECK && fmtIsBit && s_r.blk[`DG_W_FAMILY] == `DG_FAM_LARGE |=>
      s_r.st == S_WRSTAT && s_r.code == `DG_ST_BIT_LARGE)
    else $error("bit format accepted for larger family");
  // Request must not move while the link side has not taken it
  AST_LINK_HOLD: assert property (@(posedge clk) disable iff (rst)
    linkReqValid && !linkReqReady |=> linkReqValid && $stable(linkReqKind))
    else $error("link request dropped before it was taken");
  // A wrong block length never reaches the link
  AST_LEN_CHECK: assert property (@(posedge clk) disable iff (rst)
    ce && goReq && s_r.st == S_IDLE &&
      s_r.blk[`DG_W_LEN] != 16'(nFmt * `DG_FMT_WORDS + `DG_LEN_BASE) |=>
      s_r.st == S_WRSTAT && s_r.code != `DG_ST_OK)
    else $error("bad block length accepted");
  // Element count outside its range ends the check loop
  AST_CNT_RANGE: assert property (@(posedge clk) disable iff (rst)
    ce && s_r.st == S_CHECK && (s_r.blk[7'(fmtBase + 7'd2)] < `DG_CNT_MIN ||
      s_r.blk[7'(fmtBase + 7'd2)] > `DG_CNT_MAX) |=>
      s_r.st == S_WRSTAT && s_r.code == `DG_ST_BAD_CNT)
    else $error("element count out of range accepted");
endmodule // datagram_establish_command

// [verilog/dg_consts.svh]
// Constants of the establish-datagram command interpreter
`ifndef DG_CONSTS_SVH
`define DG_CONSTS_SVH
`define DG_CMD_ESTABLISH 16'h1C2F
`define DG_FAM_LARGE 16'h0000
`define DG_FAM_SMALL 16'h0001
`define DG_TYPE_NORMAL 16'h0001
`define DG_TYPE_PERM 16'h0081
`define DG_LEN_BASE 16'h000B
`define DG_FMT_WORDS 16'h0003
`define DG_MAX_FMT 16'h0020
`define DG_CNT_MIN 16'h0001
`define DG_CNT_MAX 16'h0100
`define DG_BLK_WORDS 113
`define DG_ID_COUNT 256
`define DG_ID_ALL 8'hFF
`define DG_GROUP_SHIFT 3
`define DG_BIT_LO1 16'h0046
`define DG_BIT_HI1 16'h0056
`define DG_BIT_LO2 16'h0096
`define DG_BIT_HI2 16'h00B8
`define DG_W_LEN 0
`define DG_W_STYPE 2
`define DG_W_SADDR 3
`define DG_W_CMD 6
`define DG_W_FAMILY 7
`define DG_W_DTYPE 8
`define DG_W_IDTYPE 10
`define DG_W_IDADDR 11
`define DG_W_NFMT 16
`define DG_W_FMT0 17
`define DG_A_CTRL 12'h200
`define DG_A_STATUS 12'h204
`define DG_A_ID 12'h208
`define DG_A_QUERY 12'h20C
`define DG_A_BLK_END 12'h1C4
`define DG_ST_OK 16'h0001
`define DG_ST_BAD_CMD 16'h0101
`define DG_ST_NOT_ATT 16'h0201
`define DG_ST_BAD_FAM 16'h0301
`define DG_ST_BAD_TYPE 16'h0401
`define DG_ST_BAD_NFMT 16'h0501
`define DG_ST_BAD_LEN 16'h0601
`define DG_ST_BAD_CNT 16'h0701
`define DG_ST_BIT_LARGE 16'h0801
`define DG_ST_BIT_SPAN 16'h0901
`define DG_ST_TIMEOUT 16'h0A01
`define DG_ST_REJECT 16'h0B01
`define DG_LK_EST 1'b0
`define DG_LK_WRITE 1'b1
`define DG_TIMEOUT_US 1000
`define DG_CLK_KHZ 40000
`endif

// [verilog/dg_fmt_check.sv]
// Checks one three-word point format
`timescale 1ns/1ps
`include "dg_consts.svh"
module dg_fmt_check (
  input wire logic [15:0] family,
  input wire logic [15:0] memType,
  input wire logic [15:0] startAddr,
  input wire logic [15:0] count,
  output logic isBit,
  output logic [15:0] errCode
);
  logic [15:0] firstEl;
  logic [15:0] lastEl;

  // Bit-mode memory types sit on even codes in two bands
  always_comb begin
    isBit = !memType[0] &&
      ((memType >= `DG_BIT_LO1 && memType <= `DG_BIT_HI1) ||
       (memType >= `DG_BIT_LO2 && memType <= `DG_BIT_HI2));
    firstEl = startAddr - 16'h0001;
    lastEl = firstEl + count - 16'h0001;
    errCode = 16'h0000;
    if (count < `DG_CNT_MIN || count > `DG_CNT_MAX) begin
      errCode = `DG_ST_BAD_CNT;
    end else if (isBit && family == `DG_FAM_LARGE) begin
      errCode = `DG_ST_BIT_LARGE;
    end else if (isBit && (firstEl >> `DG_GROUP_SHIFT) != (lastEl >> `DG_GROUP_SHIFT)) begin
      // Caught here so a bad span never reaches the slave
      errCode = `DG_ST_BIT_SPAN;
    end
  end
endmodule // dg_fmt_check

// [verilog/dg_pkg.sv]
// Types shared by the datagram command interpreter
package dg_pkg;
  typedef enum logic [7:0] {
    S_IDLE = 8'h01,
    S_CHECK = 8'h02,
    S_SEND1 = 8'h04,
    S_WAIT1 = 8'h08,
    S_SEND2 = 8'h10,
    S_WAIT2 = 8'h20,
    S_WRID = 8'h40,
    S_WRSTAT = 8'h80
  } dg_state_type;

  typedef struct packed {
    logic [255:0] valid;
    logic [255:0] perm;
  } table_state_type;

  typedef struct packed {
    dg_state_type st;
    logic [112:0][15:0] blk;
    logic ack;
    logic [31:0] rdat;
    logic [5:0] fmtIdx;
    logic [31:0] tmr;
    logic [15:0] code;
    logic [7:0] id;
    logic idValid;
    logic estDone;
    logic chkOk;
    logic memV;
    logic [15:0] memT;
    logic [15:0] memA;
    logic [15:0] memD;
    logic lreqV;
    logic lreqK;
    logic setV;
    logic [7:0] queryId;
  } top_state_type;
endpackage

// [verilog/dg_table.sv]
// Validity table of established datagram identifiers
`timescale 1ns/1ps
`include "dg_consts.svh"
module dg_table
  import dg_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic setValid,
  input wire logic [7:0] setId,
  input wire logic setPerm,
  input wire logic attachEvt,
  input wire logic rtUpdEvt,
  input wire logic cancelEvt,
  input wire logic [7:0] cancelId,
  input wire logic cancelPerm,
  input wire logic powerLoss,
  input wire logic progDelete,
  input wire logic [7:0] queryId,
  output logic queryValid
);
  table_state_type s_r;
  table_state_type s_nxt;

  // Clears first, then the set, so a new entry wins over a same-cycle clear
  always_comb begin
    s_nxt = s_r;
    if (attachEvt || rtUpdEvt) begin
      s_nxt.valid = s_r.valid & s_r.perm;
    end
    if (powerLoss || progDelete) begin
      s_nxt.valid = s_nxt.valid & ~s_r.perm;
    end
    if (cancelEvt) begin
      for (int i = 0; i < `DG_ID_COUNT; i++) begin
        if ((cancelId == `DG_ID_ALL || cancelId == 8'(i)) && s_r.perm[i] == cancelPerm) begin
          s_nxt.valid[i] = 1'b0;
        end
      end
    end
    if (setValid) begin
      s_nxt.valid[setId] = 1'b1;
      s_nxt.perm[setId] = setPerm;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Lookup for later update commands
  assign queryValid = s_r.valid[queryId];

  AST_NORMAL_DROP: assert property (@(posedge clk) disable iff (rst)
    ce && (attachEvt || rtUpdEvt) && !setValid |=> (s_r.valid & ~s_r.perm) == '0)
    else $error("normal datagram survived attach");
  AST_PERM_KEEP: assert property (@(posedge clk) disable iff (rst)
    ce && attachEvt && !cancelEvt && !powerLoss && !progDelete |=>
      (($past(s_r.valid) & $past(s_r.perm)) & ~(s_r.valid & s_r.perm)) == '0)
    else $error("permanent datagram lost on attach");
  AST_SET_WINS: assert property (@(posedge clk) disable iff (rst)
    ce && setValid |=> s_r.valid[$past(setId)])
    else $error("new identifier not valid");
endmodule // dg_table
